// ==== core/mdm_control.sv ====
`timescale 1ns/1ps
// ********************************************************
// Multiplier, accumulator and divider control
// ********************************************************
module mdm_control
(
  input  wire logic                       CLOCK_I,
  input  wire logic                       RST_I,
  input  wire logic [mdm_pkg::ADDR_W-1:0] ADDR_I,
  input  wire logic [mdm_pkg::DATA_W-1:0] WDATA_I,
  input  wire logic                       WR_I,
  input  wire logic                       BIT_WR_I,
  input  wire logic [mdm_pkg::BITPOS_W-1:0] BIT_POS_I,
  input  wire logic                       BIT_VAL_I,
  input  wire logic                       RD_I,
  output logic      [mdm_pkg::DATA_W-1:0] RDATA_O,
  output logic                            ARITH_DONE_IRQ_O
);
  import mdm_pkg::*;

  // ********************************************************
  // Declarations
  // ********************************************************
  logic [CTRL_W-1:0] ctrl_reg;
  logic [CTRL_W-1:0] ctrl_next;
  logic [DATA_W-1:0] op_a_low_reg;
  logic [DATA_W-1:0] op_a_high_reg;
  logic [DATA_W-1:0] res_b_low_reg;
  logic [DATA_W-1:0] res_b_high_reg;
  logic [DATA_W-1:0] acc_c_low_reg;
  logic [DATA_W-1:0] acc_c_high_reg;
  mdm_stage_e        state_reg;
  mdm_stage_e        state_next;
  logic              irq_next;

  logic              wr_ctrl;
  logic              bit_wr;
  logic              sw_ctrl_wr;
  logic [CTRL_W-1:0] bit_mask;
  logic [CTRL_W-1:0] ctrl_bitmod;
  logic [CTRL_W-1:0] sw_val;
  logic              wr_al;
  logic              wr_ah;
  logic              wr_bl;
  logic              wr_bh;
  logic              wr_cl;
  logic              wr_ch;

  logic              mode_div;
  logic              mode_acc;
  logic              mode_sgn;
  logic              mode_div_n;
  logic              mode_acc_n;
  logic              mode_sgn_n;
  logic              run_set;
  logic              run_n;
  logic              ovf_n;
  logic              sign_n;
  logic              div_start;
  logic              div_done;
  logic              mul_trig;
  logic              acc_step;

  logic [OP_W-1:0]        prod_u;
  logic signed [OP_W-1:0] prod_s;
  logic [OP_W-1:0]        prod_w;
  logic [OP_W-1:0]        acc_val;
  logic [OP_W-1:0]        prod_val;
  logic [OP_W:0]          sum_w;
  logic                   ovf_u;
  logic                   ovf_s;
  logic                   ovf_now;
  logic [DATA_W-1:0]      rd_mux;

  mdm_div_if div_bus ();

  // ********************************************************
  // Register access decode
  // ********************************************************
  // Byte and bit writes both land on the control register
  assign wr_ctrl     = WR_I && (ADDR_I == ADDR_CTRL);
  assign bit_wr      = BIT_WR_I && (ADDR_I == ADDR_CTRL);
  assign sw_ctrl_wr  = wr_ctrl || bit_wr;
  assign bit_mask    = 8'h01 << BIT_POS_I;
  assign ctrl_bitmod = BIT_VAL_I ? (ctrl_reg | bit_mask)
                                 : (ctrl_reg & ~bit_mask);
  assign sw_val      = wr_ctrl ? WDATA_I[CTRL_W-1:0] : ctrl_bitmod;

  // Data registers take 16-bit writes only
  assign wr_al = WR_I && (ADDR_I == ADDR_A_LOW);
  assign wr_ah = WR_I && (ADDR_I == ADDR_A_HIGH);
  assign wr_bl = WR_I && (ADDR_I == ADDR_B_LOW);
  assign wr_bh = WR_I && (ADDR_I == ADDR_B_HIGH);
  assign wr_cl = WR_I && (ADDR_I == ADDR_C_LOW);
  assign wr_ch = WR_I && (ADDR_I == ADDR_C_HIGH);

  // ********************************************************
  // Mode decode and control register next value
  // ********************************************************
  // Current mode; division masks the accumulate and signed selects
  assign mode_div = ctrl_reg[BIT_DIV];
  assign mode_acc = ctrl_reg[BIT_ACC] && !mode_div;
  assign mode_sgn = ctrl_reg[BIT_SGN] && !mode_div;

  // Selects change only on a processor write
  assign mode_div_n = sw_ctrl_wr ? sw_val[BIT_DIV] : ctrl_reg[BIT_DIV];
  assign mode_acc_n = sw_ctrl_wr ? sw_val[BIT_ACC] : ctrl_reg[BIT_ACC];
  assign mode_sgn_n = sw_ctrl_wr ? sw_val[BIT_SGN] : ctrl_reg[BIT_SGN];

  // Run sets only in division mode and cannot be cleared by software
  assign run_set   = sw_ctrl_wr && sw_val[BIT_RUN] && mode_div_n;
  assign div_done  = div_bus.done;
  assign run_n     = div_done ? 1'b0
                              : (ctrl_reg[BIT_RUN] || run_set);
  assign div_start = run_set && !ctrl_reg[BIT_RUN];

  // Flags move with accumulation, sign also on a C high write in signed accumulate; control writes skip them
  assign ovf_n  = acc_step ? ovf_now : ctrl_reg[BIT_OVF];
  assign sign_n = acc_step ? (mode_sgn && sum_w[OP_W-1])
                : (wr_ch && mode_acc && mode_sgn) ? WDATA_I[DATA_W-1]
                : ctrl_reg[BIT_SIGN];

  // Bits 5 and 4 are wired to zero
  assign ctrl_next = {mode_div_n, mode_acc_n, 2'b00,
                      mode_sgn_n, ovf_n, sign_n, run_n};

  // ********************************************************
  // Multiply and accumulate datapath
  // ********************************************************
  // Operand A low times operand A high, either signedness
  assign prod_u = op_a_low_reg * op_a_high_reg;
  assign prod_s = $signed(op_a_low_reg) * $signed(op_a_high_reg);
  assign prod_w = mode_sgn ? prod_s : prod_u;

  // Accumulator plus the product latched in the result registers
  assign acc_val  = {acc_c_high_reg, acc_c_low_reg};
  assign prod_val = {res_b_high_reg, res_b_low_reg};
  assign sum_w    = {1'b0, acc_val} + {1'b0, prod_val};

  // Carry out for unsigned, same-sign flip for signed
  assign ovf_u   = sum_w[OP_W];
  assign ovf_s   = (acc_val[OP_W-1] == prod_val[OP_W-1]) &&
                   (sum_w[OP_W-1] != acc_val[OP_W-1]);
  assign ovf_now = mode_sgn ? ovf_s : ovf_u;

  // Only a multiplier write starts a multiply, never a control write
  assign mul_trig = wr_ah && !mode_div;
  assign acc_step = (state_reg == ST_ACC);

  // Divider sees the stored dividend and divisor at start
  assign div_bus.start    = div_start;
  assign div_bus.dividend = {op_a_high_reg, op_a_low_reg};
  assign div_bus.divisor  = {res_b_high_reg, res_b_low_reg};

  // Done interrupt from division or accumulate overflow
  assign irq_next = (div_done && !ctrl_reg[BIT_ACC]) ||
                    (acc_step && ovf_now);

  // ********************************************************
  // Sequencer
  // ********************************************************
  // Multiply in one clock, accumulate in the next
  always_comb
  begin
    state_next = ST_IDLE;
    case (state_reg)
      ST_IDLE: state_next = ST_IDLE;
      ST_MUL:  state_next = mode_acc ? ST_ACC : ST_IDLE;
      ST_ACC:  state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
    if (mul_trig)
    begin
      state_next = ST_MUL;
    end
  end

  // ********************************************************
  // Registers
  // ********************************************************
  // Control register and sequencer
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      ctrl_reg         <= CTRL_RESET;
      state_reg        <= ST_IDLE;
      ARITH_DONE_IRQ_O <= 1'b0;
    end
    else
    begin
      ctrl_reg         <= ctrl_next;
      state_reg        <= state_next;
      ARITH_DONE_IRQ_O <= irq_next;
    end
  end

  // Operand A holds multiplicand, multiplier or dividend/quotient
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      op_a_low_reg  <= DATA_RESET;
      op_a_high_reg <= DATA_RESET;
    end
    else if (div_done)
    begin
      op_a_low_reg  <= div_bus.quotient[DATA_W-1:0];
      op_a_high_reg <= div_bus.quotient[OP_W-1:DATA_W];
    end
    else
    begin
      if (wr_al)
      begin
        op_a_low_reg <= WDATA_I;
      end
      if (wr_ah)
      begin
        op_a_high_reg <= WDATA_I;
      end
    end
  end

  // Result B: product out, divisor in; hardware wins a collision
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      res_b_low_reg  <= DATA_RESET;
      res_b_high_reg <= DATA_RESET;
    end
    else if (state_reg == ST_MUL)
    begin
      res_b_low_reg  <= prod_w[DATA_W-1:0];
      res_b_high_reg <= prod_w[OP_W-1:DATA_W];
    end
    else
    begin
      if (wr_bl)
      begin
        res_b_low_reg <= WDATA_I;
      end
      if (wr_bh)
      begin
        res_b_high_reg <= WDATA_I;
      end
    end
  end

  // Accumulator C: sum, remainder or software preset
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      acc_c_low_reg  <= DATA_RESET;
      acc_c_high_reg <= DATA_RESET;
    end
    else if (acc_step)
    begin
      acc_c_low_reg  <= sum_w[DATA_W-1:0];
      acc_c_high_reg <= sum_w[OP_W-1:DATA_W];
    end
    else if (div_done)
    begin
      acc_c_low_reg  <= div_bus.remainder[DATA_W-1:0];
      acc_c_high_reg <= div_bus.remainder[OP_W-1:DATA_W];
    end
    else
    begin
      if (wr_cl)
      begin
        acc_c_low_reg <= WDATA_I;
      end
      if (wr_ch)
      begin
        acc_c_high_reg <= WDATA_I;
      end
    end
  end

  // ********************************************************
  // Read port
  // ********************************************************
  // Unmapped addresses read zero; control sits in the low byte
  assign rd_mux =
    (ADDR_I == ADDR_CTRL)   ? {8'h00, ctrl_reg} :
    (ADDR_I == ADDR_A_LOW)  ? op_a_low_reg   :
    (ADDR_I == ADDR_A_HIGH) ? op_a_high_reg  :
    (ADDR_I == ADDR_B_LOW)  ? res_b_low_reg  :
    (ADDR_I == ADDR_B_HIGH) ? res_b_high_reg :
    (ADDR_I == ADDR_C_LOW)  ? acc_c_low_reg  :
    (ADDR_I == ADDR_C_HIGH) ? acc_c_high_reg : DATA_RESET;

  // Read data registered, held until the next read
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      RDATA_O <= DATA_RESET;
    end
    else if (RD_I)
    begin
      RDATA_O <= rd_mux;
    end
  end

  // ********************************************************
  // Divider core
  // ********************************************************
  mdm_divider u_divider
  (
    .clk_i  (CLOCK_I),
    .rst_i  (RST_I),
    .div_if (div_bus)
  );

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I);

  a_reset_clears:
    assert property ($fell(RST_I) |-> ctrl_reg == CTRL_RESET)
    else $error("control not zero after reset");

  a_zero_bits:
    assert property (ctrl_reg[5:4] == 2'b00)
    else $error("control bits 5 and 4 not zero");

  a_flags_ro:
    assert property (sw_ctrl_wr && !acc_step
                     |=> $stable(ctrl_reg[BIT_OVF:BIT_SIGN]))
    else $error("processor write changed a flag");

  a_run_div_only:
    assert property ($rose(ctrl_reg[BIT_RUN]) |-> ctrl_reg[BIT_DIV])
    else $error("run set outside division mode");

  a_div_length:
    assert property ($rose(ctrl_reg[BIT_RUN])
                     |-> ##15 ctrl_reg[BIT_RUN] ##1 !ctrl_reg[BIT_RUN])
    else $error("division did not last 16 clocks");

  a_no_abort:
    assert property (ctrl_reg[BIT_RUN] && sw_ctrl_wr &&
                     !sw_val[BIT_RUN] && !div_done
                     |=> ctrl_reg[BIT_RUN])
    else $error("software aborted a division");

  a_div_irq_mask:
    assert property (div_done && ctrl_reg[BIT_ACC]
                     |=> !ARITH_DONE_IRQ_O)
    else $error("masked division raised interrupt");

  a_mul_product:
    assert property (mul_trig && !mode_sgn |-> ##2
      ({res_b_high_reg, res_b_low_reg} ==
       $past(op_a_low_reg) * $past(op_a_high_reg)))
    else $error("unsigned product wrong or late");

  a_signed_sign:
    assert property (mul_trig && mode_sgn && WDATA_I != DATA_RESET &&
                     op_a_low_reg != DATA_RESET |-> ##2
      (res_b_high_reg[DATA_W-1] ==
       ($past(op_a_low_reg[DATA_W-1]) ^ $past(op_a_high_reg[DATA_W-1]))))
    else $error("signed product sign wrong");

  a_acc_timing:
    assert property (mul_trig && mode_acc
                     |=> state_reg == ST_MUL ##1 state_reg == ST_ACC)
    else $error("accumulate not two clocks after write");

  a_acc_sum:
    assert property (acc_step |=> {acc_c_high_reg, acc_c_low_reg} ==
      $past({acc_c_high_reg, acc_c_low_reg}) +
      $past({res_b_high_reg, res_b_low_reg}))
    else $error("accumulated value wrong");

  a_unsigned_ovf:
    assert property (acc_step && !mode_sgn
                     |=> ctrl_reg[BIT_OVF] == $past(sum_w[OP_W])
                         && !ctrl_reg[BIT_SIGN])
    else $error("unsigned overflow or sign flag wrong");

  a_ovf_irq:
    assert property (acc_step && ovf_now
                     |=> ARITH_DONE_IRQ_O && ctrl_reg[BIT_OVF])
    else $error("overflow without interrupt");
endmodule : mdm_control

// ==== core/mdm_divider.sv ====
`timescale 1ns/1ps
// ********************************************************
// Unsigned 32/32 restoring divider, two bits per clock
// ********************************************************
module mdm_divider
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  mdm_div_if.core   div_if
);
  import mdm_pkg::*;

  localparam int STEP_BITS = OP_W / DIV_CYCLES;

  logic [DIV_CNT_W-1:0] cnt_reg;
  logic [OP_W-1:0]      quo_reg;
  logic [OP_W-1:0]      dsr_reg;
  logic [OP_W:0]        rem_reg;
  logic [OP_W-1:0]      quo_next;
  logic [OP_W:0]        rem_next;

  // One clock of work; remainder needs a guard bit after the shift
  always_comb
  begin
    quo_next = quo_reg;
    rem_next = rem_reg;
    for (int i = 0; i < STEP_BITS; i++)
    begin
      rem_next = {rem_next[OP_W-1:0], quo_next[OP_W-1]};
      quo_next = {quo_next[OP_W-2:0], 1'b0};
      if (rem_next >= {1'b0, dsr_reg})
      begin
        rem_next    = rem_next - {1'b0, dsr_reg};
        quo_next[0] = 1'b1;
      end
    end
  end

  // Load on start, then step until the count runs out
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= '0;
      quo_reg <= '0;
      dsr_reg <= '0;
      rem_reg <= '0;
    end
    else if (div_if.start)
    begin
      cnt_reg <= DIV_CNT_W'(DIV_CYCLES);
      quo_reg <= div_if.dividend;
      dsr_reg <= div_if.divisor;
      rem_reg <= '0;
    end
    else if (cnt_reg != '0)
    begin
      cnt_reg <= cnt_reg - 1'b1;
      quo_reg <= quo_next;
      rem_reg <= rem_next;
    end
  end

  // Results are the last step's values, taken by the caller
  assign div_if.done      = (cnt_reg == DIV_CNT_W'(1));
  assign div_if.quotient  = quo_next;
  assign div_if.remainder = rem_next[OP_W-1:0];
endmodule : mdm_divider

// ==== inc/mdm_div_if.sv ====
`timescale 1ns/1ps
// ********************************************************
// Link between control logic and divider core
// ********************************************************
interface mdm_div_if;
  import mdm_pkg::*;
  logic            start;
  logic [OP_W-1:0] dividend;
  logic [OP_W-1:0] divisor;
  logic            done;
  logic [OP_W-1:0] quotient;
  logic [OP_W-1:0] remainder;
  modport ctrl (output start, dividend, divisor,
                input  done, quotient, remainder);
  modport core (input  start, dividend, divisor,
                output done, quotient, remainder);
endinterface : mdm_div_if

// ==== inc/mdm_pkg.sv ====
// ********************************************************
// Shared constants of the arithmetic unit
// ********************************************************
package mdm_pkg;
  // Widths
  localparam int ADDR_W   = 20;
  localparam int DATA_W   = 16;
  localparam int CTRL_W   = 8;
  localparam int OP_W     = 32;
  localparam int BITPOS_W = 3;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_C_LOW  = 20'hF_00E0;
  localparam logic [ADDR_W-1:0] ADDR_C_HIGH = 20'hF_00E2;
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 20'hF_00E8;
  localparam logic [ADDR_W-1:0] ADDR_A_LOW  = 20'hF_00F0;
  localparam logic [ADDR_W-1:0] ADDR_A_HIGH = 20'hF_00F2;
  localparam logic [ADDR_W-1:0] ADDR_B_LOW  = 20'hF_00F4;
  localparam logic [ADDR_W-1:0] ADDR_B_HIGH = 20'hF_00F6;

  // Control register field positions
  localparam int BIT_DIV  = 7;
  localparam int BIT_ACC  = 6;
  localparam int BIT_SGN  = 3;
  localparam int BIT_OVF  = 2;
  localparam int BIT_SIGN = 1;
  localparam int BIT_RUN  = 0;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

  // Timing counts in operation clocks
  localparam int MUL_CYCLES = 1;
  localparam int DIV_CYCLES = 16;
  localparam int DIV_CNT_W  = 5;

  // Multiply and accumulate sequencing
  typedef enum logic [1:0] {ST_IDLE, ST_MUL, ST_ACC} mdm_stage_e;
endpackage : mdm_pkg

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench of the arithmetic unit control block
// ****************************************************************
module testbench;
  import mdm_pkg::*;
  logic                clk;
  logic                rst;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wdata;
  logic                wr;
  logic                bit_wr;
  logic [BITPOS_W-1:0] bit_pos;
  logic                bit_val;
  logic                rd;
  logic [DATA_W-1:0]   rdata;
  logic                irq;
  int                  failures;
  int                  checks_done;
  int                  irq_count;
  int                  irq_exp;
  logic [31:0]         seed;
  logic [15:0]         last_lo;
  logic [15:0]         flag_bits;

  mdm_control dut
  (
    .CLOCK_I          (clk),
    .RST_I            (rst),
    .ADDR_I           (addr),
    .WDATA_I          (wdata),
    .WR_I             (wr),
    .BIT_WR_I         (bit_wr),
    .BIT_POS_I        (bit_pos),
    .BIT_VAL_I        (bit_val),
    .RD_I             (rd),
    .RDATA_O          (rdata),
    .ARITH_DONE_IRQ_O (irq)
  );

  // Clock at 10 MHz
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Count interrupt pulses; each lasts one cycle
  always @(posedge clk)
  begin
    if (irq === 1'b1) irq_count++;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Reference product; signed path sign-extends both operands
  function automatic logic [31:0] prod(logic [15:0] a, logic [15:0] b,
                                       logic sgn);
    logic signed [31:0] sa;
    logic signed [31:0] sb;
    sa = $signed(a);
    sb = $signed(b);
    if (sgn) return sa * sb;
    return {16'h0000, a} * {16'h0000, b};
  endfunction : prod

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Inputs change on the falling edge; the rising edge samples them
  task automatic wr16(logic [ADDR_W-1:0] a, logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr16

  task automatic bitw(int pos, logic v);
    @(negedge clk);
    addr = ADDR_CTRL;
    bit_pos = pos[BITPOS_W-1:0];
    bit_val = v;
    bit_wr = 1'b1;
    @(negedge clk);
    bit_wr = 1'b0;
  endtask : bitw

  task automatic rd_chk(string what, logic [ADDR_W-1:0] a,
                        logic [15:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    check(what, {16'h0000, exp}, {16'h0000, rdata});
  endtask : rd_chk

  // Multiply; only_hi reuses the multiplicand already held
  task automatic mul_case(logic sgn, logic [15:0] lo, logic [15:0] hi,
                          logic only_hi);
    logic [31:0] p;
    if (!only_hi) wr16(ADDR_A_LOW, lo);
    if (!only_hi) last_lo = lo;
    wr16(ADDR_A_HIGH, hi);
    @(negedge clk);
    p = prod(last_lo, hi, sgn);
    rd_chk("product low", ADDR_B_LOW, p[15:0]);
    rd_chk("product high", ADDR_B_HIGH, p[31:16]);
  endtask : mul_case

  // Accumulate with flag and interrupt expectations
  task automatic acc_case(logic sgn, logic [31:0] c, logic [15:0] lo,
                          logic [15:0] hi);
    logic [31:0] p;
    logic [32:0] s;
    logic        ovf;
    p = prod(lo, hi, sgn);
    s = {1'b0, c} + {1'b0, p};
    ovf = sgn ? (c[31] == p[31]) && (s[31] != c[31]) : s[32];
    // Flags stay until the next accumulate or signed accumulate C high write; division reads see them
    flag_bits = {8'h00, 5'h00, ovf, sgn & s[31], 1'b0};
    wr16(ADDR_C_HIGH, c[31:16]);
    wr16(ADDR_C_LOW, c[15:0]);
    wr16(ADDR_A_LOW, lo);
    wr16(ADDR_A_HIGH, hi);
    repeat (2) @(negedge clk);
    if (ovf) irq_exp++;
    rd_chk("accum low", ADDR_C_LOW, s[15:0]);
    rd_chk("accum high", ADDR_C_HIGH, s[31:16]);
    rd_chk("acc product", ADDR_B_HIGH, p[31:16]);
    rd_chk("acc flags", ADDR_CTRL,
           {8'h00, 2'b01, 2'b00, sgn, ovf, sgn & s[31], 1'b0});
    check("acc irq", irq_exp, irq_count);
  endtask : acc_case

  // Division; quiet selects the mode without completion interrupt
  task automatic div_case(logic quiet, logic [31:0] dvd, logic [31:0] dvs);
    logic [15:0] mode;
    logic [31:0] q;
    logic [31:0] r;
    mode = quiet ? 16'h00C0 : 16'h0080;
    q = (dvs == 0) ? 32'hFFFF_FFFF : dvd / dvs;
    r = (dvs == 0) ? dvd : dvd % dvs;
    wr16(ADDR_CTRL, mode);
    wr16(ADDR_A_HIGH, dvd[31:16]);
    wr16(ADDR_A_LOW, dvd[15:0]);
    wr16(ADDR_B_HIGH, dvs[31:16]);
    wr16(ADDR_B_LOW, dvs[15:0]);
    check("no irq yet", irq_exp, irq_count);
    wr16(ADDR_CTRL, mode | 16'h0001);
    rd_chk("run bit set", ADDR_CTRL,
           mode | flag_bits | 16'h0001);
    wr16(ADDR_CTRL, mode);
    rd_chk("run not aborted", ADDR_CTRL,
           mode | flag_bits | 16'h0001);
    repeat (12) @(negedge clk);
    if (!quiet) irq_exp++;
    rd_chk("run cleared", ADDR_CTRL, mode | flag_bits);
    rd_chk("quotient low", ADDR_A_LOW, q[15:0]);
    rd_chk("quotient high", ADDR_A_HIGH, q[31:16]);
    rd_chk("remainder low", ADDR_C_LOW, r[15:0]);
    rd_chk("remainder high", ADDR_C_HIGH, r[31:16]);
    check("div irq", irq_exp, irq_count);
  endtask : div_case

  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {addr, wdata, wr, bit_wr, bit_pos, bit_val, rd} = '0;
    failures = 0;
    checks_done = 0;
    irq_count = 0;
    irq_exp = 0;
    last_lo = 16'h0000;
    flag_bits = 16'h0000;
    seed = 32'd30347;
    rst = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    rd_chk("ctrl reset", ADDR_CTRL, 16'h0000);
    rd_chk("unmapped", 20'hF_00EA, 16'h0000);
    // Read-only flags, fixed zeros and run bit outside division
    wr16(ADDR_CTRL, 16'h003F);
    rd_chk("ctrl masked", ADDR_CTRL, 16'h0008);
    bitw(3, 1'b0);
    bitw(0, 1'b1);
    bitw(2, 1'b1);
    rd_chk("bit run refused", ADDR_CTRL, 16'h0000);
    bitw(6, 1'b1);
    bitw(5, 1'b1);
    rd_chk("bit write", ADDR_CTRL, 16'h0040);
    check("ctrl irq", irq_exp, irq_count);
    $display("test control done");
    // Multiply, unsigned then signed, corners then random
    for (int m = 0; m < 2; m++)
    begin
      wr16(ADDR_CTRL, m ? 16'h0008 : 16'h0000);
      mul_case(m[0], 16'h0002, 16'h0003, 1'b0);
      mul_case(m[0], 16'hFFFF, 16'hFFFF, 1'b0);
      mul_case(m[0], 16'hFFFE, 16'h7FFF, 1'b0);
      mul_case(m[0], 16'h8000, 16'h8000, 1'b0);
      for (int i = 0; i < 8; i++)
      begin
        mul_case(m[0], rnd() >> 16, rnd() >> 16, 1'b0);
        mul_case(m[0], 16'h0000, rnd() >> 16, 1'b1);
      end
    end
    $display("test multiply done");
    // Accumulate, unsigned then signed
    wr16(ADDR_CTRL, 16'h0040);
    acc_case(1'b0, 32'hFFFF_FFFF, 16'h0001, 16'h0001);
    acc_case(1'b0, 32'h0000_0005, 16'h0002, 16'h0003);
    acc_case(1'b0, rnd(), rnd() >> 16, rnd() >> 16);
    wr16(ADDR_CTRL, 16'h0048);
    acc_case(1'b1, 32'hFFFF_FFFC, 16'h0002, 16'h0003);
    acc_case(1'b1, 32'h8000_0001, 16'h7FFF, 16'hFFFF);
    acc_case(1'b1, 32'h7FFF_FFFF, 16'h0001, 16'h0001);
    for (int i = 0; i < 4; i++)
      acc_case(1'b1, rnd(), rnd() >> 16, rnd() >> 16);
    $display("test accumulate done");
    // Division with and without interrupt, zero divisor too
    div_case(1'b0, 32'd100, 32'd7);
    div_case(1'b1, rnd(), rnd() >> 20);
    div_case(1'b0, rnd(), 32'h0000_0000);
    div_case(1'b0, rnd(), rnd() | 32'h0000_0001);
    $display("test divide done");
    conclude();
  end

  // Watchdog well beyond the expected several hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule : testbench
